// File: hw/crs_count_rate_scaler.sv
// Count scaler, totalizer, rate meter and output drivers
//
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/100ps
// Summary of operation
// RULE1 - Each counted pulse adds the count scaler to main counter and totalizer.
// RULE2 - Count scaler writes outside 0.00001 to 9.99999 are refused.
// RULE3 - Count scaler resets to exactly 1.00000.
// RULE4 - Only whole counts are shown; the fraction is kept for later pulses.
// RULE5 - Counter and rate decimal points are set separately, 0 to 5 digits.
// RULE6 - Doubled modes make two events per pulse, each one scaled.
// RULE7 - Rate is the reciprocal of the pulse interval times the rate weight.
// RULE8 - Rate weight accepts 0.00001 to 99999 and resets to one.
// RULE9 - Rate is measured from count input A alone.
// RULE10 - A control input is active while pulled low to common.
// RULE11 - A transistor output sinks while picked up, else released.
// RULE12 - A relay stays normal until pickup, then held until dropout.
// RULE13 - All relays are off after power-up, whatever their sense.
// RULE14 - Doubled quadrature and direction modes count on both edges.
// RULE15 - The rate value updates after each complete interval on input A; intervals that end while the divider is busy are skipped.
// RULE16 - Both scalers are fixed point with five decimal fraction digits.
module crs_count_rate_scaler #(
  parameter int PERIOD_W = 32
) (
  input wire logic clk_sys_in,                      // System clock
  input wire logic sys_rst_in,                      // Async reset
  input wire logic ce_in,                           // Clock enable
  input wire logic cnt_a_in,                        // Count input A pin
  input wire logic cnt_b_in,                        // Count input B pin
  input wire logic [crs_pkg::CRS_NUM_CTRL-1:0] ctrl_n_in, // Control pins
  input wire logic [crs_pkg::CRS_ADDR_W-1:0] addr_in,     // Reg address
  input wire logic [crs_pkg::CRS_DATA_W-1:0] wr_data_in,  // Write data
  input wire logic wr_in,                           // Write strobe
  input wire logic rd_in,                           // Read strobe
  output logic [crs_pkg::CRS_DATA_W-1:0] rd_data_out,     // Read data
  output logic [31:0] main_count_out,               // Main whole count
  output logic [31:0] total_out,                    // Totalizer whole
  output logic [31:0] rate_out,                     // Scaled rate
  output logic [crs_pkg::CRS_DP_W-1:0] cnt_dp_out,  // Counter dp digits
  output logic [crs_pkg::CRS_DP_W-1:0] rate_dp_out, // Rate dp digits
  output logic [1:0] relay_out,                     // Relay coil drive
  output logic [1:0] tr_sink_out,                   // Transistor sink on
  output logic [crs_pkg::CRS_NUM_CTRL-1:0] ctrl_active_out // Inputs on
);
  import crs_pkg::*;

  // Splits a fixed-point sum into whole carry and fraction
  function automatic crs_split_type crs_norm(input logic signed [23:0] s);
    crs_split_type res;
    logic signed [23:0] r;
    logic signed [23:0] u;
    logic signed [7:0] q;
    u = $signed({3'h0, CRS_UNIT});
    r = s;
    q = '0;
    for (int i = 0; i < CRS_CARRY_MAX; i++) begin
      if (r >= u) begin
        r = r - u;
        q = q + 8'sh01;
      end else if (r < 0) begin
        r = r + u;
        q = q - 8'sh01;
      end
    end
    res.carry = q;
    res.rem = r[16:0];
    return res;
  endfunction

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [CRS_NUM_IN-1:0] raw, s1_q, s2_q, s3_q, filt_q, filt_d, prev_q;

  assign raw = {ctrl_n_in, cnt_b_in, cnt_a_in};

  always_comb begin
    filt_d = filt_q;
    for (int i = 0; i < CRS_NUM_IN; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        filt_d[i] = s3_q[i];
      end
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
      filt_q <= '1;
      prev_q <= '1;
    end else if (ce_in) begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_q <= filt_d;
      prev_q <= filt_q;
    end
  end

  // ---------------------------------------------------------------
  // Count event decode
  // ---------------------------------------------------------------
  logic a_rise, a_fall, b_rise, b_lvl;
  logic signed [2:0] n_ev;
  logic [1:0] n_mag;
  crs_mode_type mode_q;

  assign a_rise = filt_q[0] & ~prev_q[0];
  assign a_fall = ~filt_q[0] & prev_q[0];
  assign b_rise = filt_q[1] & ~prev_q[1];
  assign b_lvl = filt_q[1];

  always_comb begin
    n_ev = 3'sh0;
    case (mode_q)
      CRS_ADD_SUB: n_ev = (a_rise && !b_rise) ? 3'sh1 :
                          (b_rise && !a_rise) ? -3'sh1 : 3'sh0;
      CRS_ADD_ADD: n_ev = 3'(a_rise) + 3'(b_rise);           // RULE6
      CRS_CDIR_X1: if (a_rise) n_ev = b_lvl ? 3'sh1 : -3'sh1;
      CRS_CDIR_X2: if (a_rise || a_fall) begin               // RULE14
        n_ev = b_lvl ? 3'sh1 : -3'sh1;                       // RULE6
      end
      CRS_QUAD_X1: if (a_rise) n_ev = b_lvl ? -3'sh1 : 3'sh1;
      CRS_QUAD_X2: if (a_rise) begin                         // RULE14
        n_ev = b_lvl ? -3'sh1 : 3'sh1;
      end else if (a_fall) begin
        n_ev = b_lvl ? 3'sh1 : -3'sh1;                       // RULE6
      end
      default: n_ev = 3'sh0;
    endcase
    n_mag = (n_ev < 0) ? 2'(-n_ev) : 2'(n_ev);
  end

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  logic en_q, en_d, refused_q, refused_d;
  crs_mode_type mode_d;
  logic [2:0] cdp_q, cdp_d, rdp_q, rdp_d;
  logic [1:0] rev_q, rev_d, rw_stage_q, rw_stage_d;
  logic [19:0] cs_q, cs_d;
  logic [33:0] rw_q, rw_d, rw_new;
  logic [2:0] wr_mode, wr_cdp, wr_rdp;

  assign wr_mode = wr_data_in[CRS_CTRL_MODE +: 3];
  assign wr_cdp = wr_data_in[CRS_CTRL_CDP +: 3];
  assign wr_rdp = wr_data_in[CRS_CTRL_RDP +: 3];
  assign rw_new = {rw_stage_q, wr_data_in};

  always_comb begin
    en_d = en_q;
    mode_d = mode_q;
    cdp_d = cdp_q;
    rdp_d = rdp_q;
    rev_d = rev_q;
    cs_d = cs_q;
    rw_d = rw_q;
    rw_stage_d = rw_stage_q;
    refused_d = refused_q;
    if (wr_in) begin
      refused_d = 1'b0;
      case (addr_in)
        CRS_REG_CTRL:
          if (wr_mode > CRS_MODE_LAST || wr_cdp > CRS_DP_MAX ||
              wr_rdp > CRS_DP_MAX) begin
            refused_d = 1'b1;                                // RULE5
          end else begin
            en_d = wr_data_in[CRS_CTRL_EN];
            mode_d = crs_mode_type'(wr_mode);
            cdp_d = wr_cdp;                                  // RULE5
            rdp_d = wr_rdp;                                  // RULE5
            rev_d = wr_data_in[CRS_CTRL_REV +: 2];
          end
        CRS_REG_CSCALE:
          if (wr_data_in < 32'(CRS_CS_MIN) ||
              wr_data_in > 32'(CRS_CS_MAX)) begin
            refused_d = 1'b1;                                // RULE2
          end else begin
            cs_d = wr_data_in[19:0];                         // RULE16
          end
        CRS_REG_RW_HI: rw_stage_d = wr_data_in[1:0];
        CRS_REG_RW_LO:
          if (rw_new < CRS_RW_MIN || rw_new > CRS_RW_MAX) begin
            refused_d = 1'b1;                                // RULE8
          end else begin
            rw_d = rw_new;                                   // RULE16
          end
        default: refused_d = refused_q;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      en_q <= 1'b1;
      mode_q <= CRS_ADD_SUB;
      cdp_q <= '0;
      rdp_q <= '0;
      rev_q <= '0;
      cs_q <= CRS_CS_DEF;                                    // RULE3
      rw_q <= CRS_RW_DEF;                                    // RULE8
      rw_stage_q <= '0;
      refused_q <= 1'b0;
    end else if (ce_in) begin
      en_q <= en_d;
      mode_q <= mode_d;
      cdp_q <= cdp_d;
      rdp_q <= rdp_d;
      rev_q <= rev_d;
      cs_q <= cs_d;
      rw_q <= rw_d;
      rw_stage_q <= rw_stage_d;
      refused_q <= refused_d;
    end
  end

  // ---------------------------------------------------------------
  // Main counter and totalizer
  // ---------------------------------------------------------------
  logic signed [31:0] main_q, main_d;
  logic [31:0] tot_q, tot_d;
  logic [16:0] mfrac_q, mfrac_d, tfrac_q, tfrac_d;
  logic clr_main, clr_tot;

  assign clr_main = wr_in && addr_in == CRS_REG_CMD &&
                    wr_data_in[CRS_CMD_CLR_MAIN];
  assign clr_tot = wr_in && addr_in == CRS_REG_CMD &&
                   wr_data_in[CRS_CMD_CLR_TOT];

  always_comb begin
    crs_split_type sm;
    crs_split_type st;
    logic signed [23:0] cs_s;
    cs_s = $signed({4'h0, cs_q});
    sm = crs_norm($signed({7'h0, mfrac_q}) + 24'(n_ev) * cs_s); // RULE1
    st = crs_norm($signed({7'h0, tfrac_q}) +
                  $signed({22'h0, n_mag}) * cs_s);           // RULE1
    main_d = main_q;
    mfrac_d = mfrac_q;
    tot_d = tot_q;
    tfrac_d = tfrac_q;
    if (en_q && n_ev != 3'sh0) begin
      main_d = main_q + 32'(sm.carry);                       // RULE4
      mfrac_d = sm.rem;                                      // RULE4
      tot_d = tot_q + 32'(st.carry);                         // RULE4
      tfrac_d = st.rem;
    end
    if (clr_main) begin
      main_d = '0;
      mfrac_d = '0;
    end
    if (clr_tot) begin
      tot_d = '0;
      tfrac_d = '0;
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      main_q <= '0;
      mfrac_q <= '0;
      tot_q <= '0;
      tfrac_q <= '0;
    end else if (ce_in) begin
      main_q <= main_d;
      mfrac_q <= mfrac_d;
      tot_q <= tot_d;
      tfrac_q <= tfrac_d;
    end
  end

  // ---------------------------------------------------------------
  // Rate meter
  // ---------------------------------------------------------------
  crs_rate_if rif ();
  logic [31:0] rate_q, rate_d;

  assign rif.ce = ce_in;
  assign rif.pulse = a_rise;                                 // RULE9
  assign rif.weight = rw_q;

  crs_rate_meter #(.PERIOD_W(PERIOD_W)) u_meter (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .rif(rif.meter)
  );

  assign rate_d = rif.done ? rif.rate : rate_q;              // RULE15

  // ---------------------------------------------------------------
  // Relay and transistor outputs
  // ---------------------------------------------------------------
  logic [CRS_NUM_OUT-1:0] out_q, out_d, pick, drop;
  logic [1:0] relay_q, relay_d, tr_q, tr_d;
  logic [CRS_NUM_CTRL-1:0] act_q, act_d;

  assign pick = (wr_in && addr_in == CRS_REG_CMD) ?
                wr_data_in[CRS_CMD_PICK +: CRS_NUM_OUT] : '0;
  assign drop = (wr_in && addr_in == CRS_REG_CMD) ?
                wr_data_in[CRS_CMD_DROP +: CRS_NUM_OUT] : '0;

  always_comb begin
    out_d = (out_q & ~drop) | pick;                          // RULE12
    relay_d = relay_q;
    for (int i = 0; i < 2; i++) begin
      if (pick[i]) begin
        relay_d[i] = ~rev_q[i];                              // RULE12
      end else if (drop[i]) begin
        relay_d[i] = rev_q[i];                               // RULE12
      end
    end
    tr_d = out_d[3:2];                                       // RULE11
    act_d = ~filt_q[CRS_NUM_IN-1:2];                         // RULE10
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      out_q <= '0;
      relay_q <= '0;                                         // RULE13
      tr_q <= '0;
      act_q <= '0;
      rate_q <= '0;
    end else if (ce_in) begin
      out_q <= out_d;
      relay_q <= relay_d;
      tr_q <= tr_d;
      act_q <= act_d;
      rate_q <= rate_d;
    end
  end

  // ---------------------------------------------------------------
  // Register read port
  // ---------------------------------------------------------------
  logic [31:0] rd_q, rd_d;

  always_comb begin
    rd_d = '0;
    if (rd_in) begin
      case (addr_in)
        CRS_REG_CTRL: begin
          rd_d[CRS_CTRL_EN] = en_q;
          rd_d[CRS_CTRL_MODE +: 3] = mode_q;
          rd_d[CRS_CTRL_CDP +: 3] = cdp_q;
          rd_d[CRS_CTRL_RDP +: 3] = rdp_q;
          rd_d[CRS_CTRL_REV +: 2] = rev_q;
        end
        CRS_REG_CSCALE: rd_d = 32'(cs_q);
        CRS_REG_RW_LO: rd_d = rw_q[31:0];
        CRS_REG_RW_HI: rd_d = 32'(rw_q[33:32]);
        CRS_REG_MAIN: rd_d = main_q;
        CRS_REG_MFRAC: rd_d = 32'(mfrac_q);
        CRS_REG_TOTAL: rd_d = tot_q;
        CRS_REG_RATE: rd_d = rate_q;
        CRS_REG_STATUS: begin
          rd_d[CRS_ST_CTRL +: CRS_NUM_CTRL] = act_q;
          rd_d[CRS_ST_OUT +: CRS_NUM_OUT] = out_q;
          rd_d[CRS_ST_BUSY] = rif.busy;
          rd_d[CRS_ST_REFUSED] = refused_q;
        end
        default: rd_d = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rd_q <= '0;
    end else if (ce_in) begin
      rd_q <= rd_d;
    end
  end

  assign rd_data_out = rd_q;
  assign main_count_out = main_q;
  assign total_out = tot_q;
  assign rate_out = rate_q;
  assign cnt_dp_out = cdp_q;
  assign rate_dp_out = rdp_q;
  assign relay_out = relay_q;
  assign tr_sink_out = tr_q;
  assign ctrl_active_out = act_q;
endmodule

// File: hw/crs_rate_meter.sv
// Reciprocal rate meter: period timer and sequential divider
`timescale 1ns/100ps
module crs_rate_meter #(
  parameter int PERIOD_W = 32
) (
  input wire logic clk_sys_in,  // System clock
  input wire logic sys_rst_in,  // Async reset, active high
  crs_rate_if.meter rif         // Link to the counting core
);
  import crs_pkg::*;

  localparam int DEN_W = PERIOD_W + CRS_UNIT_W;
  localparam int REM_W = DEN_W + 1;
  localparam logic [PERIOD_W-1:0] PER_MAX = '1;

  if (PERIOD_W < 8 || PERIOD_W > 40) begin : g_bad_width
    $error("crs_rate_meter: PERIOD_W out of range");
  end

  typedef enum logic {CRS_IDLE, CRS_DIV} crs_div_state_type;

  crs_div_state_type st_q, st_d;
  logic [PERIOD_W-1:0] per_q, per_d;
  logic seen_q, seen_d;
  logic [5:0] cnt_q, cnt_d;
  logic [63:0] num_q, num_d;
  logic [REM_W-1:0] rem_q, rem_d;
  logic [DEN_W-1:0] den_q, den_d;
  logic [31:0] rate_q, rate_d;
  logic done_q, done_d;

  // ---------------------------------------------------------------
  // Interval timing and division
  // ---------------------------------------------------------------
  always_comb begin
    logic [REM_W-1:0] trial;
    trial = '0;
    st_d = st_q;
    per_d = per_q;
    seen_d = seen_q;
    cnt_d = cnt_q;
    num_d = num_q;
    rem_d = rem_q;
    den_d = den_q;
    rate_d = rate_q;
    done_d = rif.ce ? 1'b0 : done_q;
    if (rif.ce) begin
      if (per_q != PER_MAX) begin
        per_d = per_q + 1'b1;
      end
      case (st_q)
        CRS_IDLE: begin
        end
        CRS_DIV: begin
          rem_d = {rem_q[REM_W-2:0], num_q[63]};
          num_d = {num_q[62:0], 1'b0};
          trial = rem_d - {1'b0, den_q};
          if (rem_d >= {1'b0, den_q}) begin
            rem_d = trial;
            num_d[0] = 1'b1;
          end
          cnt_d = cnt_q + 1'b1;
          if (cnt_q == 6'h3F) begin
            st_d = CRS_IDLE;
            rate_d = (|num_d[63:32]) ? 32'hFFFF_FFFF : num_d[31:0]; // RULE7
            done_d = 1'b1;                                        // RULE15
          end
        end
        default: st_d = CRS_IDLE;
      endcase
      if (rif.pulse) begin                                  // RULE9
        per_d = {{(PERIOD_W-1){1'b0}}, 1'b1};
        seen_d = 1'b1;
        if (seen_q && st_q == CRS_IDLE) begin
          if (per_q == PER_MAX) begin
            rate_d = 32'h0000_0000;
            done_d = 1'b1;                                  // RULE15
          end else begin
            // Rate = weight * f_clk / (period * unit)
            num_d = 64'(rif.weight * CRS_CLK_HZ);           // RULE7
            den_d = DEN_W'(per_q * CRS_UNIT);
            rem_d = '0;
            cnt_d = '0;
            st_d = CRS_DIV;
          end
        end
      end
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st_q <= CRS_IDLE;
      per_q <= '0;
      seen_q <= 1'b0;
      cnt_q <= '0;
      num_q <= '0;
      rem_q <= '0;
      den_q <= '0;
      rate_q <= '0;
      done_q <= 1'b0;
    end else begin
      st_q <= st_d;
      per_q <= per_d;
      seen_q <= seen_d;
      cnt_q <= cnt_d;
      num_q <= num_d;
      rem_q <= rem_d;
      den_q <= den_d;
      rate_q <= rate_d;
      done_q <= done_d;
    end
  end

  assign rif.rate = rate_q;
  assign rif.done = done_q;
  assign rif.busy = (st_q == CRS_DIV);
endmodule

// File: pkg/crs_pkg.sv
// Constants, register map and types of the count and rate scaler
package crs_pkg;
  // ---------------------------------------------------------------
  // Clock and fixed-point scaling
  // ---------------------------------------------------------------
  localparam int CRS_CLK_PERIOD_NS = 5;
  localparam logic [63:0] CRS_NS_PER_S = 64'h3B9A_CA00;
  localparam logic [63:0] CRS_CLK_HZ = CRS_NS_PER_S / CRS_CLK_PERIOD_NS;
  localparam logic [20:0] CRS_UNIT = 21'h186A0;
  localparam int CRS_UNIT_W = 17;
  localparam int CRS_CARRY_MAX = 24;
  localparam logic [19:0] CRS_CS_MIN = 20'h00001;
  localparam logic [19:0] CRS_CS_MAX = 20'hF423F;
  localparam logic [19:0] CRS_CS_DEF = 20'h186A0;
  localparam logic [33:0] CRS_RW_MIN = 34'h0_0000_0001;
  localparam logic [33:0] CRS_RW_MAX = 34'h2_540A_5D60;
  localparam logic [33:0] CRS_RW_DEF = 34'h0_0001_86A0;
  localparam int CRS_DP_W = 3;
  localparam logic [2:0] CRS_DP_MAX = 3'h5;
  // ---------------------------------------------------------------
  // Register bus and map (word indices)
  // ---------------------------------------------------------------
  localparam int CRS_ADDR_W = 4;
  localparam int CRS_DATA_W = 32;
  localparam logic [3:0] CRS_REG_CTRL = 4'h0;
  localparam logic [3:0] CRS_REG_CSCALE = 4'h1;
  localparam logic [3:0] CRS_REG_RW_LO = 4'h2;
  localparam logic [3:0] CRS_REG_RW_HI = 4'h3;
  localparam logic [3:0] CRS_REG_CMD = 4'h4;
  localparam logic [3:0] CRS_REG_MAIN = 4'h5;
  localparam logic [3:0] CRS_REG_MFRAC = 4'h6;
  localparam logic [3:0] CRS_REG_TOTAL = 4'h7;
  localparam logic [3:0] CRS_REG_RATE = 4'h8;
  localparam logic [3:0] CRS_REG_STATUS = 4'h9;
  // CTRL fields
  localparam int CRS_CTRL_EN = 0;
  localparam int CRS_CTRL_MODE = 1;
  localparam int CRS_CTRL_CDP = 4;
  localparam int CRS_CTRL_RDP = 7;
  localparam int CRS_CTRL_REV = 10;
  // CMD fields
  localparam int CRS_CMD_CLR_MAIN = 0;
  localparam int CRS_CMD_CLR_TOT = 1;
  localparam int CRS_CMD_PICK = 4;
  localparam int CRS_CMD_DROP = 8;
  // STATUS fields
  localparam int CRS_ST_CTRL = 0;
  localparam int CRS_ST_OUT = 4;
  localparam int CRS_ST_BUSY = 8;
  localparam int CRS_ST_REFUSED = 9;
  // ---------------------------------------------------------------
  // Pins and types
  // ---------------------------------------------------------------
  localparam int CRS_NUM_CTRL = 4;
  localparam int CRS_NUM_OUT = 4;
  localparam int CRS_NUM_IN = 6;
  typedef enum logic [2:0] {
    CRS_ADD_SUB,
    CRS_ADD_ADD,
    CRS_CDIR_X1,
    CRS_CDIR_X2,
    CRS_QUAD_X1,
    CRS_QUAD_X2
  } crs_mode_type;
  localparam logic [2:0] CRS_MODE_LAST = 3'h5;
  typedef struct packed {
    logic signed [7:0] carry;
    logic [16:0] rem;
  } crs_split_type;
endpackage

// File: pkg/crs_rate_if.sv
// Link between the counting core and the rate meter
`timescale 1ns/100ps
interface crs_rate_if;
  logic ce;
  logic pulse;
  logic [33:0] weight;
  logic [31:0] rate;
  logic done;
  logic busy;
  modport core (output ce, output pulse, output weight,
                input rate, input done, input busy);
  modport meter (input ce, input pulse, input weight,
                 output rate, output done, output busy);
endinterface

// File: verification/crs_count_rate_scaler_asserts.sv
// Port checker for the count and rate scaler
`timescale 1ns/100ps
module crs_count_rate_scaler_asserts #(
  parameter int PERIOD_W = 32
) (
  input wire logic clk_sys_in, // Clock
  input wire logic sys_rst_in, // Reset
  input wire logic ce_in, // Enable
  input wire logic cnt_a_in, // Count A
  input wire logic [3:0] ctrl_n_in, // Control pins
  input wire logic [3:0] addr_in, // Address
  input wire logic [31:0] wr_data_in, // Write data
  input wire logic wr_in, // Write strobe
  input wire logic [31:0] rate_out, // Rate
  input wire logic [2:0] cnt_dp_out, // Counter dp
  input wire logic [2:0] rate_dp_out, // Rate dp
  input wire logic [1:0] relay_out, // Relays
  input wire logic [1:0] tr_sink_out, // Transistors
  input wire logic [3:0] ctrl_active_out // Inputs on
);
  import crs_pkg::*;
  logic [7:0] a_idle_q, a_idle_d;
  logic rev_q, rev_d;
  logic cmd_wr, ctrl_ok;
  always_comb begin
    cmd_wr = ce_in && wr_in && addr_in == CRS_REG_CMD;
    ctrl_ok = ce_in && wr_in && addr_in == CRS_REG_CTRL &&
              wr_data_in[3:1] <= 3'h5 && wr_data_in[6:4] <= 3'h5 &&
              wr_data_in[9:7] <= 3'h5;
    // Cycles since input A was last seen low
    a_idle_d = (a_idle_q == 8'hFF) ? a_idle_q : a_idle_q + 8'h01;
    if (!cnt_a_in) begin
      a_idle_d = 8'h00;
    end
    rev_d = ctrl_ok ? wr_data_in[10] : rev_q;
  end
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      a_idle_q <= 8'h00;
      rev_q <= 1'b0;
    end else begin
      a_idle_q <= a_idle_d;
      rev_q <= rev_d;
    end
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  chk_relay_power_off: assert property ($fell(sys_rst_in) |->
    relay_out == 2'h0) else $error("relay on after reset");
  chk_relay_pick_sense: assert property (cmd_wr && wr_data_in[4] |=>
    relay_out[0] == !$past(rev_q)) else $error("relay pickup wrong");
  chk_relay_drop_sense: assert property (cmd_wr && wr_data_in[8] &&
    !wr_data_in[4] |=> relay_out[0] == $past(rev_q))
    else $error("relay dropout wrong");
  chk_relay_hold_state: assert property (!cmd_wr |=>
    $stable(relay_out)) else $error("relay moved without event");
  chk_tr_pick_sink: assert property (cmd_wr && wr_data_in[6] |=>
    tr_sink_out[0]) else $error("transistor not sinking");
  chk_tr_drop_release: assert property (cmd_wr && wr_data_in[11] &&
    !wr_data_in[7] |=> !tr_sink_out[1]) else $error("transistor held");
  chk_ctrl_low_on: assert property (ctrl_n_in == 4'h0 [*8] |=>
    ctrl_active_out == 4'hF) else $error("control input not on");
  chk_ctrl_high_off: assert property (ctrl_n_in == 4'hF [*8] |=>
    ctrl_active_out == 4'h0) else $error("control input not off");
  chk_dp_follow_write: assert property (ctrl_ok |=>
    cnt_dp_out == $past(wr_data_in[6:4]) &&
    rate_dp_out == $past(wr_data_in[9:7])) else $error("dp not updated");
  chk_rate_a_only: assert property (a_idle_q == 8'hFF |=>
    $stable(rate_out)) else $error("rate moved without input A");
  cover property (cmd_wr && wr_data_in[4]);
  cover property (ctrl_ok && wr_data_in[6:4] == 3'h5);
  cover property (a_idle_q == 8'hFE && rate_out != 32'h0);
endmodule
bind crs_count_rate_scaler crs_count_rate_scaler_asserts #(
  .PERIOD_W(PERIOD_W)) crs_count_rate_scaler_asserts_inst (.*);

// File: verification/crs_pulse_model.sv
// Pulse sensor model driving count inputs A and B
`timescale 1ns/100ps
module crs_pulse_model (
  input wire logic clk_in, // Sensor timing clock
  output logic a_out, // Count input A
  output logic b_out // Count input B
);
  // Lines idle high, as with an open sensor and pull-up
  initial begin
    a_out = 1'b1;
    b_out = 1'b1;
  end
  // Each pulse goes low then high, half cycles each phase
  task train(input bit on_b, input int n, input int half);
    repeat (2 * n) begin
      repeat (half) @(posedge clk_in);
      if (on_b) begin
        b_out <= ~b_out;
      end else begin
        a_out <= ~a_out;
      end
    end
  endtask
endmodule

// File: verification/tb.sv
// Testbench for the count and rate scaler
`timescale 1ns/100ps
module tb;
  import crs_pkg::*;
  logic clk_sys_in = 1'b0, sys_rst_in = 1'b1, ce_in = 1'b1;
  logic wr_in = 1'b0, rd_in = 1'b0, cnt_a, cnt_b;
  logic [3:0] ctrl_n_in = 4'hF, addr_in = 4'h0, act;
  logic [31:0] wr_data_in = 32'h0, rd_data_out, main, total, rate, d;
  logic [2:0] cdp, rdp;
  logic [1:0] relay, tr;
  logic [31:0] em [6] = '{2, 2, 2, 4, 32'hFFFFFFFE, 0};
  logic [31:0] et [6] = '{2, 2, 2, 4, 2, 4};
  int num_errors = 0, n_compared = 0;
  initial forever #2.5 clk_sys_in = ~clk_sys_in;
  crs_count_rate_scaler crs_count_rate_scaler_inst (
    .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .ce_in(ce_in),
    .cnt_a_in(cnt_a), .cnt_b_in(cnt_b), .ctrl_n_in(ctrl_n_in),
    .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_in(wr_in),
    .rd_in(rd_in), .rd_data_out(rd_data_out), .main_count_out(main),
    .total_out(total), .rate_out(rate), .cnt_dp_out(cdp),
    .rate_dp_out(rdp), .relay_out(relay), .tr_sink_out(tr),
    .ctrl_active_out(act));
  crs_pulse_model crs_pulse_model_inst (.clk_in(clk_sys_in),
    .a_out(cnt_a), .b_out(cnt_b));
  task wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_sys_in);
    addr_in <= a;
    wr_data_in <= v;
    wr_in <= 1'b1;
    @(posedge clk_sys_in);
    wr_in <= 1'b0;
    @(negedge clk_sys_in);
  endtask
  task rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk_sys_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_sys_in);
    rd_in <= 1'b0;
    @(negedge clk_sys_in);
    v = rd_data_out;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task rchk(input logic [3:0] a, input logic [31:0] exp);
    rd(a, d);
    chk(d, exp);
  endtask
  task settle(input int n);
    repeat (n) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
  endtask
  task results();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (10000) @(posedge clk_sys_in);
    num_errors++;
    results();
  end
  initial begin
    repeat (6) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    settle(0);
    chk(32'(relay), 32'h0);
    rchk(CRS_REG_CSCALE, 32'd100000);
    rchk(CRS_REG_RW_LO, 32'd100000);
    wr(CRS_REG_CSCALE, 32'h0);
    rchk(CRS_REG_STATUS, 32'h200);
    wr(CRS_REG_CSCALE, 32'd1000000);
    rchk(CRS_REG_CSCALE, 32'd100000);
    wr(CRS_REG_CSCALE, 32'd999999);
    rchk(CRS_REG_CSCALE, 32'd999999);
    rchk(4'hF, 32'h0);
    $display("test scaler limits done");
    wr(CRS_REG_CSCALE, 32'd50000);
    crs_pulse_model_inst.train(1'b0, 3, 4);
    settle(10);
    rchk(CRS_REG_MAIN, 32'h1);
    rchk(CRS_REG_MFRAC, 32'd50000);
    chk(total, 32'h1);
    $display("test fractional scaling done");
    wr(CRS_REG_CSCALE, 32'd100000);
    for (int m = 0; m < 6; m++) begin
      wr(CRS_REG_CTRL, {28'h0, 3'(m), 1'b1});
      wr(CRS_REG_CMD, 32'h3);
      crs_pulse_model_inst.train(1'b0, 2, 4);
      settle(10);
      chk(main, em[m]);
      chk(total, et[m]);
    end
    $display("test count modes done");
    wr(CRS_REG_CTRL, 32'h151);
    chk(32'(cdp), 32'h5);
    chk(32'(rdp), 32'h2);
    wr(CRS_REG_CTRL, 32'h61);
    chk(32'(cdp), 32'h5);
    $display("test decimal points done");
    wr(CRS_REG_CMD, 32'hD0);
    chk(32'(relay), 32'h1);
    chk(32'(tr), 32'h3);
    wr(CRS_REG_CMD, 32'hD00);
    chk(32'(relay), 32'h0);
    chk(32'(tr), 32'h0);
    wr(CRS_REG_CTRL, 32'h951);
    wr(CRS_REG_CMD, 32'h200);
    chk(32'(relay), 32'h2);
    wr(CRS_REG_CMD, 32'h220);
    chk(32'(relay), 32'h0);
    @(posedge clk_sys_in) ctrl_n_in <= 4'hA;
    settle(10);
    chk(32'(act), 32'h5);
    @(posedge clk_sys_in) ctrl_n_in <= 4'h0;
    settle(10);
    chk(32'(act), 32'hF);
    $display("test outputs and inputs done");
    wr(CRS_REG_RW_HI, 32'h0);
    wr(CRS_REG_RW_LO, 32'd300000);
    crs_pulse_model_inst.train(1'b0, 3, 50);
    settle(90);
    chk(rate, 32'd6000000);
    crs_pulse_model_inst.train(1'b1, 3, 10);
    settle(100);
    chk(rate, 32'd6000000);
    wr(CRS_REG_RW_HI, 32'h2);
    wr(CRS_REG_RW_LO, 32'h540A5D61);
    rd(CRS_REG_STATUS, d);
    chk(32'(d[9]), 32'h1);
    rchk(CRS_REG_RW_LO, 32'd300000);
    $display("test rate meter done");
    results();
  end
endmodule
